// ### design/dscg_defs.vh
// Constants for the deep-sleep clock gating block
`ifndef DSCG_DEFS_VH
`define DSCG_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses, low 12 bits)
// ****************************************************************
`define DSCG_ADDR_W          12
`define DSCG_OFF_DEEP        12'h124
`define DSCG_OFF_RUN         12'h104
`define DSCG_OFF_SLEEP       12'h114
`define DSCG_OFF_MODE        12'h060
`define DSCG_OFF_STATUS      12'h130

// ****************************************************************
// Gate bit positions
// ****************************************************************
`define DSCG_BIT_CMP2        26
`define DSCG_BIT_CMP1        25
`define DSCG_BIT_CMP0        24
`define DSCG_BIT_TMR2        18
`define DSCG_BIT_TMR1        17
`define DSCG_BIT_TMR0        16
`define DSCG_BIT_TWI         12
`define DSCG_BIT_SSI         4
`define DSCG_BIT_ASI         0
`define DSCG_GATE_MASK       32'h07071011
`define DSCG_GATE_RESET      32'h00000000

// ****************************************************************
// Mode register fields
// ****************************************************************
`define DSCG_BIT_AUTO        27
`define DSCG_MODE_MASK       32'h08000000
`define DSCG_MODE_RESET      32'h00000000

// ****************************************************************
// Status register fields
// ****************************************************************
`define DSCG_ST_DEEP         0
`define DSCG_ST_SLEEP        1
`define DSCG_ST_AUTO         2
`define DSCG_ZERO            32'h00000000

// ****************************************************************
// Register select vector
// ****************************************************************
`define DSCG_SEL_W           5
`define DSCG_SEL_DEEP        0
`define DSCG_SEL_RUN         1
`define DSCG_SEL_SLEEP       2
`define DSCG_SEL_MODE        3
`define DSCG_SEL_STATUS      4
`define DSCG_SEL_NONE        5'h00

// ****************************************************************
// Bus lanes
// ****************************************************************
`define DSCG_STRB_W          4
`define DSCG_LANE_W          8

// ****************************************************************
// Unit indices into the enable vector
// ****************************************************************
`define DSCG_NUM_UNITS       9
`define DSCG_ENABLE_RESET    9'h000
`define DSCG_U_ASI           0
`define DSCG_U_SSI           1
`define DSCG_U_TWI           2
`define DSCG_U_TMR0          3
`define DSCG_U_TMR1          4
`define DSCG_U_TMR2          5
`define DSCG_U_CMP0          6
`define DSCG_U_CMP1          7
`define DSCG_U_CMP2          8

`endif

// ### design/dscg_clk_gate.v
// Glitch-free latch-based clock gate for one unit
`timescale 1ns/1ps
module dscg_clk_gate (
  // Clock in
  input  wire clk_in,
  // Enable, same domain as clk_in
  input  wire enable,
  // Gated clock
  output wire clk_out
);
  reg en_lat;

  // Latch transparent while clock low
  always @* begin
    if (!clk_in) begin
      en_lat = enable;
    end else begin
      en_lat = en_lat;
    end
  end

  assign clk_out = clk_in & en_lat;
endmodule

// ### design/dscg_top.v
// Deep-sleep clock gating control with APB register slave
`timescale 1ns/1ps
`include "dscg_defs.vh"
module dscg_top (
  // System clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  // Power state from the core, same clock
  input  wire        sleep_req,
  input  wire        deep_sleep_req,
  // Peripheral access check
  input  wire        unit_sel_valid,
  input  wire [3:0]  unit_sel,
  output wire        unit_bus_fault,
  // Unit enables and gated clocks
  output reg  [8:0]  unit_enable,
  output wire [8:0]  unit_clk
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [31:0] deep_sleep_clock_gate_1_r;
  reg [31:0] run_clock_gate_1_r;
  reg [31:0] sleep_clock_gate_1_r;
  reg [31:0] run_clock_configuration_r;
  reg [31:0] active_gate;
  reg [31:0] rd_nxt;
  wire       auto_sleep_gating_select;
  wire       acc_phase;
  wire       wr_en;
  wire       rd_en;
  wire [`DSCG_ADDR_W-1:0] off;
  wire [`DSCG_SEL_W-1:0]  reg_hit;
  wire       comparator_two_gate;
  wire       comparator_one_gate;
  wire       comparator_zero_gate;
  wire       timer_two_gate;
  wire       timer_one_gate;
  wire       timer_zero_gate;
  wire       two_wire_unit_gate;
  wire       sync_serial_unit_gate;
  wire       async_serial_unit_gate;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [31:0] apply_strb;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    input [31:0] mask;
    integer i;
    begin
      apply_strb = old;
      for (i = 0; i < `DSCG_STRB_W; i = i + 1) begin
        if (st[i]) begin
          apply_strb[i*`DSCG_LANE_W +: `DSCG_LANE_W] = wd[i*`DSCG_LANE_W +: `DSCG_LANE_W];
        end
      end
      apply_strb = apply_strb & mask;
    end
  endfunction

  // One-hot register select from the byte offset
  function [`DSCG_SEL_W-1:0] reg_sel;
    input [`DSCG_ADDR_W-1:0] a;
    begin
      reg_sel = `DSCG_SEL_NONE;
      case (a)
        `DSCG_OFF_DEEP:   reg_sel[`DSCG_SEL_DEEP]   = 1'b1;
        `DSCG_OFF_RUN:    reg_sel[`DSCG_SEL_RUN]    = 1'b1;
        `DSCG_OFF_SLEEP:  reg_sel[`DSCG_SEL_SLEEP]  = 1'b1;
        `DSCG_OFF_MODE:   reg_sel[`DSCG_SEL_MODE]   = 1'b1;
        `DSCG_OFF_STATUS: reg_sel[`DSCG_SEL_STATUS] = 1'b1;
        default:          reg_sel = `DSCG_SEL_NONE;
      endcase
    end
  endfunction

  // One when an access to the selected unit must fault
  function unit_fault;
    input [3:0]                 sel;
    input [`DSCG_NUM_UNITS-1:0] en;
    begin
      case (sel)
        `DSCG_U_ASI:  unit_fault = ~en[`DSCG_U_ASI];
        `DSCG_U_SSI:  unit_fault = ~en[`DSCG_U_SSI];
        `DSCG_U_TWI:  unit_fault = ~en[`DSCG_U_TWI];
        `DSCG_U_TMR0: unit_fault = ~en[`DSCG_U_TMR0];
        `DSCG_U_TMR1: unit_fault = ~en[`DSCG_U_TMR1];
        `DSCG_U_TMR2: unit_fault = ~en[`DSCG_U_TMR2];
        `DSCG_U_CMP0: unit_fault = ~en[`DSCG_U_CMP0];
        `DSCG_U_CMP1: unit_fault = ~en[`DSCG_U_CMP1];
        `DSCG_U_CMP2: unit_fault = ~en[`DSCG_U_CMP2];
        default:      unit_fault = 1'b1;
      endcase
    end
  endfunction

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign off       = paddr[`DSCG_ADDR_W-1:0];
  assign acc_phase = psel & penable;
  assign pready    = 1'b1;
  assign wr_en     = acc_phase & pwrite;
  assign rd_en     = acc_phase & ~pwrite;
  assign auto_sleep_gating_select = run_clock_configuration_r[`DSCG_BIT_AUTO];
  assign reg_hit   = reg_sel(off);

  // Unmapped offsets read zero
  always @* begin
    rd_nxt = `DSCG_ZERO;
    if (reg_hit[`DSCG_SEL_DEEP]) begin
      rd_nxt = deep_sleep_clock_gate_1_r & `DSCG_GATE_MASK;
    end
    if (reg_hit[`DSCG_SEL_RUN]) begin
      rd_nxt = run_clock_gate_1_r & `DSCG_GATE_MASK;
    end
    if (reg_hit[`DSCG_SEL_SLEEP]) begin
      rd_nxt = sleep_clock_gate_1_r & `DSCG_GATE_MASK;
    end
    if (reg_hit[`DSCG_SEL_MODE]) begin
      rd_nxt = run_clock_configuration_r & `DSCG_MODE_MASK;
    end
    if (reg_hit[`DSCG_SEL_STATUS]) begin
      rd_nxt[`DSCG_ST_DEEP]  = deep_sleep_req;
      rd_nxt[`DSCG_ST_SLEEP] = sleep_req;
      rd_nxt[`DSCG_ST_AUTO]  = auto_sleep_gating_select;
    end
  end

  // Read data and error registered in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `DSCG_ZERO;
      pslverr <= 1'b0;
    end else begin
      if (rd_en) begin
        prdata <= rd_nxt;
      end
      pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Gate registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deep_sleep_clock_gate_1_r <= `DSCG_GATE_RESET;
      run_clock_gate_1_r        <= `DSCG_GATE_RESET;
      sleep_clock_gate_1_r      <= `DSCG_GATE_RESET;
      run_clock_configuration_r <= `DSCG_MODE_RESET;
    end else if (wr_en) begin
      if (reg_hit[`DSCG_SEL_DEEP]) begin
        deep_sleep_clock_gate_1_r <= apply_strb(deep_sleep_clock_gate_1_r,
                                     pwdata, pstrb, `DSCG_GATE_MASK);
      end
      if (reg_hit[`DSCG_SEL_RUN]) begin
        run_clock_gate_1_r <= apply_strb(run_clock_gate_1_r,
                              pwdata, pstrb, `DSCG_GATE_MASK);
      end
      if (reg_hit[`DSCG_SEL_SLEEP]) begin
        sleep_clock_gate_1_r <= apply_strb(sleep_clock_gate_1_r,
                                pwdata, pstrb, `DSCG_GATE_MASK);
      end
      if (reg_hit[`DSCG_SEL_MODE]) begin
        run_clock_configuration_r <= apply_strb(run_clock_configuration_r,
                                     pwdata, pstrb, `DSCG_MODE_MASK);
      end
    end
  end

  // ****************************************************************
  // Active gate selection
  // ****************************************************************
  always @* begin
    if (auto_sleep_gating_select && deep_sleep_req) begin
      active_gate = deep_sleep_clock_gate_1_r;
    end else if (auto_sleep_gating_select && sleep_req) begin
      active_gate = sleep_clock_gate_1_r;
    end else begin
      active_gate = run_clock_gate_1_r;
    end
  end

  // ****************************************************************
  // Per-unit gate bits
  // ****************************************************************
  assign comparator_two_gate    = active_gate[`DSCG_BIT_CMP2];
  assign comparator_one_gate    = active_gate[`DSCG_BIT_CMP1];
  assign comparator_zero_gate   = active_gate[`DSCG_BIT_CMP0];
  assign timer_two_gate         = active_gate[`DSCG_BIT_TMR2];
  assign timer_one_gate         = active_gate[`DSCG_BIT_TMR1];
  assign timer_zero_gate        = active_gate[`DSCG_BIT_TMR0];
  assign two_wire_unit_gate     = active_gate[`DSCG_BIT_TWI];
  assign sync_serial_unit_gate  = active_gate[`DSCG_BIT_SSI];
  assign async_serial_unit_gate = active_gate[`DSCG_BIT_ASI];

  // Registered enables, bit order: cmp2 cmp1 cmp0 tmr2 tmr1 tmr0 twi ssi asi
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_enable <= `DSCG_ENABLE_RESET;
    end else begin
      unit_enable <= {comparator_two_gate, comparator_one_gate, comparator_zero_gate,
                      timer_two_gate, timer_one_gate, timer_zero_gate,
                      two_wire_unit_gate, sync_serial_unit_gate,
                      async_serial_unit_gate};
    end
  end

  // ****************************************************************
  // Clock gates, one per unit
  // ****************************************************************
  dscg_clk_gate u_gate_asi (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_ASI]),
    .clk_out (unit_clk[`DSCG_U_ASI])
  );

  dscg_clk_gate u_gate_ssi (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_SSI]),
    .clk_out (unit_clk[`DSCG_U_SSI])
  );

  dscg_clk_gate u_gate_twi (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_TWI]),
    .clk_out (unit_clk[`DSCG_U_TWI])
  );

  dscg_clk_gate u_gate_tmr0 (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_TMR0]),
    .clk_out (unit_clk[`DSCG_U_TMR0])
  );

  dscg_clk_gate u_gate_tmr1 (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_TMR1]),
    .clk_out (unit_clk[`DSCG_U_TMR1])
  );

  dscg_clk_gate u_gate_tmr2 (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_TMR2]),
    .clk_out (unit_clk[`DSCG_U_TMR2])
  );

  dscg_clk_gate u_gate_cmp0 (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_CMP0]),
    .clk_out (unit_clk[`DSCG_U_CMP0])
  );

  dscg_clk_gate u_gate_cmp1 (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_CMP1]),
    .clk_out (unit_clk[`DSCG_U_CMP1])
  );

  dscg_clk_gate u_gate_cmp2 (
    .clk_in  (pclk),
    .enable  (unit_enable[`DSCG_U_CMP2]),
    .clk_out (unit_clk[`DSCG_U_CMP2])
  );

  // ****************************************************************
  // Fault on access to a stopped unit
  // ****************************************************************
  assign unit_bus_fault = unit_sel_valid &
                          unit_fault(unit_sel, unit_enable);

endmodule

// ### verif/dscg_unit_model.sv
// Peripheral unit model that records gated clock edges
`timescale 1ns/1ps
module dscg_unit_model (
  // Gated unit clocks
  input  wire  [8:0] unit_clk,
  // Bit flips on each rising edge of its unit clock
  output logic [8:0] ticks = 9'h000
);
  for (genvar i = 0; i < 9; i++) begin : g_unit
    always @(posedge unit_clk[i]) ticks[i] <= ~ticks[i];
  end
endmodule

// ### verif/dscg_assertions.sv
// Port assertions for the deep-sleep clock gating block
`timescale 1ns/1ps
module dscg_checker (
  // Bus side
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Unit side
  input wire        unit_sel_valid,
  input wire [3:0]  unit_sel,
  input wire        unit_bus_fault,
  input wire [8:0]  unit_enable
);
  wire rd = psel && penable && !pwrite;
  wire on = unit_sel_valid && unit_sel < 4'h9 && unit_enable[unit_sel];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_fault_off: assert property (unit_sel_valid && !on |-> unit_bus_fault)
    else $error("fault missing");
  a_fault_on: assert property (on |-> !unit_bus_fault) else $error("bad fault");
  a_fault_idle: assert property (!unit_sel_valid |-> !unit_bus_fault)
    else $error("stray fault");
  a_fault_range: assert property (unit_sel_valid && unit_sel > 8 |-> unit_bus_fault)
    else $error("range fault");
  a_no_error: assert property (!pslverr) else $error("slave error");
  a_reset_off: assert property ($rose(presetn) |-> !unit_enable) else $error("unit on");
  a_read_mask: assert property (rd && paddr[11:0] == 12'h124
    |=> (prdata & 32'hF8F8EFEE) == 32'h0) else $error("reserved set");
  a_unmap_zero: assert property (rd && paddr[11:0] == 12'h200 |=> !prdata)
    else $error("unmapped read");
endmodule
bind dscg_top dscg_checker u_dscg_checker (.*);

// ### verif/dscg_top_tb.sv
// Self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ps
module dscg_top_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sleep_req = 0, deep_sleep_req = 0, unit_sel_valid = 0;
  logic        pready, pslverr, unit_bus_fault;
  logic [3:0]  unit_sel = 0, pstrb = 4'hF;
  logic [8:0]  unit_enable, unit_clk, ticks, t;
  logic [31:0] paddr = 0, pwdata = 0, prdata, q;
  int          num_errors = 0, n_checks = 0;
  int          pos [9] = '{0, 4, 12, 16, 17, 18, 24, 25, 26};
  always #12.5 pclk = ~pclk;
  dscg_top u_dscg_top (.*);
  dscg_unit_model u_dscg_unit_model (.unit_clk(unit_clk), .ticks(ticks));
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d = 0, logic [3:0] s = 4'hF);
    @(posedge pclk);
    pstrb <= s;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    #1 q = prdata;
  endtask
  // Enables after settling, and which units clocked in one cycle
  task automatic settle(string nm, logic [8:0] exp);
    repeat (3) @(posedge pclk);
    #1 t = ticks;
    @(posedge pclk);
    #1 chk({nm, "_enable"}, {23'h0, exp}, {23'h0, unit_enable});
    chk({nm, "_clock"}, {23'h0, exp}, {23'h0, ticks ^ t});
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #50000 num_errors++;
    test_done;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h124);
    chk("deep_reset", 0, q);
    apb(1, 12'h124, 32'hFFFFFFFF);
    apb(0, 12'h124);
    chk("deep_mask", 32'h07071011, q);
    apb(1, 12'h124, 32'h0, 4'h8);
    apb(0, 12'h124);
    chk("deep_strobe", 32'h00071011, q);
    apb(1, 12'h200, 32'hFFFFFFFF);
    apb(0, 12'h200);
    chk("unmapped", 0, q);
    $display("Register test done");
    apb(1, 12'h104, 32'h1);
    apb(1, 12'h060, 32'h08000000);
    @(posedge pclk);
    sleep_req <= 1'b1;
    deep_sleep_req <= 1'b1;
    unit_sel_valid <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1, 12'h124, 32'h1 << pos[i]);
      settle("unit", 9'h1 << i);
      for (int j = 0; j < 10; j++) begin
        @(posedge pclk);
        unit_sel <= 4'(j);
        #1 chk("fault", 32'(j != i), {31'h0, unit_bus_fault});
      end
    end
    $display("Unit test done");
    @(posedge pclk);
    deep_sleep_req <= 1'b0;
    apb(1, 12'h114, 32'h00001000);
    settle("sleep", 9'h004);
    apb(0, 12'h130);
    chk("status", 32'h6, q);
    @(posedge pclk);
    deep_sleep_req <= 1'b1;
    apb(1, 12'h060, 32'h0);
    settle("auto_off", 9'h001);
    $display("Sleep test done");
    @(posedge pclk);
    sleep_req <= 1'b0;
    deep_sleep_req <= 1'b0;
    settle("run", 9'h001);
    apb(0, 12'h104);
    chk("run_reg", 32'h1, q);
    $display("Run mode test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h124);
    chk("deep_rst2", 0, q);
    settle("rst2", 9'h000);
    $display("Reset test done");
    test_done;
  end
endmodule
